// file: bench/cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_model #(
   parameter int BOOT_CYC   = 30,
   parameter int PERIOD_CYC = 10
) (
   input  wire logic i_ref_clk,
   input  wire logic i_reset,
   input  wire logic i_run,
   output var  logic o_toggle
);
   int count;
   initial o_toggle = 1'b0;
   // boots, then toggles well inside the long window
   always @(posedge i_ref_clk) begin
      if (i_reset) begin
         count <= 0;
      end else if (i_run) begin
         count <= count + 1;
         if (count >= BOOT_CYC && count % PERIOD_CYC == 0) o_toggle <= ~o_toggle;
      end
   end
endmodule : cpu_model
`default_nettype wire

// file: bench/supervisor_chk.sv
`timescale 1ns/1ps
`default_nettype none
module supervisor_chk #(
   parameter logic [31:0] LONG_WD_CYCLES   = 32'h0000_00C8,
   parameter logic [31:0] NORMAL_WD_CYCLES = 32'h0000_0032,
   parameter logic [31:0] HOLD_CYCLES      = 32'h0000_0014,
   parameter logic [31:0] DEBOUNCE_CYCLES  = 32'h0000_0005
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_primary_supply_low,
   input wire logic i_secondary_supply_low,
   input wire logic i_aux_monitor_low,
   input wire logic i_power_fail_sense_low,
   input wire logic i_manual_reset_n,
   input wire logic i_watchdog_toggle_in,
   input wire logic i_watchdog_open,
   input wire logic o_power_fail_flag_n,
   input wire logic o_reset_out,
   input wire logic o_reset_out_a_n,
   input wire logic o_reset_out_a_oe,
   input wire logic o_reset_out_b_n,
   input wire logic o_reset_out_b_oe,
   input wire logic o_watchdog_normal,
   input wire logic o_watchdog_expired
);
   // cycles since the last reset cause, and since the toggle last moved
   logic [31:0] quiet_reg;
   logic [31:0] stuck_reg;
   logic        toggle_reg;
   logic        supply_bad;
   assign supply_bad = i_primary_supply_low | i_secondary_supply_low | i_aux_monitor_low;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         quiet_reg  <= 32'h0;
         stuck_reg  <= 32'h0;
         toggle_reg <= 1'b0;
      end else begin
         quiet_reg  <= (supply_bad | !i_manual_reset_n) ? 32'h0 : quiet_reg + {31'h0, ~&quiet_reg};
         stuck_reg  <= (o_reset_out | i_watchdog_open | (i_watchdog_toggle_in != toggle_reg))
                       ? 32'h0 : stuck_reg + 32'h1;
         toggle_reg <= i_watchdog_toggle_in;
      end
   end
   default clocking @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);
   a_pf_follows: assert property (i_power_fail_sense_low |-> !o_power_fail_flag_n)
      else $error("power-fail flag high while sense low");
   a_pf_releases: assert property (!i_power_fail_sense_low [*8] |-> o_power_fail_flag_n)
      else $error("power-fail flag held after sense recovered");
   a_supply_resets: assert property (supply_bad |-> o_reset_out)
      else $error("reset low during supply fault");
   a_pins_together: assert property (
      {o_reset_out_a_oe, o_reset_out_b_oe, o_reset_out_a_n, o_reset_out_b_n}
      == {o_reset_out, o_reset_out, 2'b00})
      else $error("open-drain resets disagree");
   a_hold_min: assert property ($fell(o_reset_out) |-> quiet_reg >= HOLD_CYCLES)
      else $error("reset released before hold time");
   a_hold_bounded: assert property (
      quiet_reg == HOLD_CYCLES + DEBOUNCE_CYCLES + 32'hC |-> !o_reset_out)
      else $error("reset held too long after causes cleared");
   a_wd_holds: assert property (o_watchdog_expired |-> ##[0:1] o_reset_out [*8])
      else $error("watchdog expiry did not hold reset");
   a_wd_bounded: assert property (!o_reset_out |-> stuck_reg < LONG_WD_CYCLES + 32'hA)
      else $error("stuck toggle not caught by watchdog");
   a_mode_clear: assert property (o_reset_out [*8] |-> !o_watchdog_normal)
      else $error("watchdog left in normal mode during reset");
endmodule : supervisor_chk
`default_nettype wire

// file: bench/supply_reset_supervisor_test.sv
`timescale 1ns/1ps
`default_nettype none
module supply_reset_supervisor_test;
   localparam int LONG = 200;
   localparam int NORM = 50;
   localparam int HOLD = 20;
   localparam int DEB  = 5;
   logic i_ref_clk, i_rst_n, i_primary_supply_low, i_secondary_supply_low, i_aux_monitor_low;
   logic i_power_fail_sense_low, i_manual_reset_n, i_watchdog_toggle_in, i_watchdog_open, run;
   logic o_power_fail_flag_n, o_reset_out, o_reset_out_a_n, o_reset_out_a_oe;
   logic o_reset_out_b_n, o_reset_out_b_oe, o_watchdog_normal, o_watchdog_expired;
   int   fail_count, n_compared, n;
   supply_reset_supervisor #(.LONG_WD_CYCLES(LONG), .NORMAL_WD_CYCLES(NORM),
      .HOLD_CYCLES(HOLD), .DEBOUNCE_CYCLES(DEB)) DUT (.i_ref_clk, .i_rst_n,
      .i_primary_supply_low, .i_secondary_supply_low, .i_aux_monitor_low,
      .i_power_fail_sense_low, .i_manual_reset_n, .i_watchdog_toggle_in, .i_watchdog_open,
      .o_power_fail_flag_n, .o_reset_out, .o_reset_out_a_n, .o_reset_out_a_oe,
      .o_reset_out_b_n, .o_reset_out_b_oe, .o_watchdog_normal, .o_watchdog_expired);
   cpu_model cpu (.i_ref_clk, .i_reset(o_reset_out), .i_run(run), .o_toggle(i_watchdog_toggle_in));
   task automatic check_bit(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask : check_bit
   task automatic check_span(input string what, input int lo, input int hi, input int got);
      n_compared++;
      if (got < lo || got > hi) begin
         fail_count++;
         $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : check_span
   // counts falling-edge samples until reset reaches the level, bounded
   task automatic wait_level(input logic lvl, output int cyc);
      cyc = 0;
      do begin
         @(negedge i_ref_clk);
         cyc++;
      end while (o_reset_out !== lvl && cyc < 1000);
   endtask : wait_level
   task automatic set_fault(input int s, input logic v);
      @(posedge i_ref_clk);
      case (s)
         0: i_primary_supply_low <= v;
         1: i_secondary_supply_low <= v;
         default: i_aux_monitor_low <= v;
      endcase
   endtask : set_fault
   task automatic bounce();
      repeat (6) begin
         i_manual_reset_n <= ~i_manual_reset_n;
         repeat ($urandom_range(1, 3)) @(posedge i_ref_clk);
      end
   endtask : bounce
   task automatic close_out();
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out
   initial begin
      i_ref_clk = 1'b0;
      forever #20 i_ref_clk = ~i_ref_clk;
   end
   initial begin
      #200000;
      fail_count++;
      close_out();
   end
   initial begin
      {i_rst_n, i_primary_supply_low, i_secondary_supply_low, i_aux_monitor_low} = 4'h0;
      {i_power_fail_sense_low, i_watchdog_open, i_manual_reset_n, run} = 4'h3;
      fail_count = 0;
      n_compared = 0;
      n = $urandom(4);
      repeat (3) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      check_bit("reset in reset", 1'b1, o_reset_out);
      @(posedge i_ref_clk) i_rst_n <= 1'b1;
      wait_level(1'b0, n);
      check_span("power-up hold", HOLD, HOLD + 10, n);
      for (int s = 0; s < 3; s++) begin
         set_fault(s, 1'b1);
         @(negedge i_ref_clk);
         check_bit("reset on fault", 1'b1, o_reset_out);
         check_bit("enables follow", 1'b1, o_reset_out_a_oe & o_reset_out_b_oe);
         repeat ($urandom_range(5, 20)) @(posedge i_ref_clk);
         set_fault(s, 1'b0);
         repeat (9) @(posedge i_ref_clk);
         set_fault(s, 1'b1);
         repeat (4) @(posedge i_ref_clk);
         set_fault(s, 1'b0);
         wait_level(1'b0, n);
         check_span("restarted hold", HOLD, HOLD + 10, n);
      end
      repeat (6) begin
         @(posedge i_ref_clk) i_power_fail_sense_low <= 1'b1;
         @(negedge i_ref_clk) check_bit("flag low", 1'b0, o_power_fail_flag_n);
         repeat ($urandom_range(1, 8)) @(posedge i_ref_clk);
         i_power_fail_sense_low <= 1'b0;
         repeat (6) @(posedge i_ref_clk);
         @(negedge i_ref_clk) check_bit("flag released", 1'b1, o_power_fail_flag_n);
         check_bit("no reset from flag", 1'b0, o_reset_out);
      end
      @(posedge i_ref_clk);
      bounce();
      i_manual_reset_n <= 1'b0;
      repeat (10) @(posedge i_ref_clk);
      bounce();
      check_bit("reset while pressed", 1'b1, o_reset_out);
      i_manual_reset_n <= 1'b1;
      wait_level(1'b0, n);
      check_span("manual hold", HOLD + DEB, HOLD + DEB + 10, n);
      repeat (100) @(posedge i_ref_clk);
      check_bit("normal mode", 1'b1, o_watchdog_normal);
      repeat ($urandom_range(0, 9)) @(posedge i_ref_clk);
      run <= 1'b0;
      wait_level(1'b1, n);
      check_span("normal timeout", NORM - 10, NORM + 8, n);
      wait_level(1'b0, n);
      check_span("watchdog hold", HOLD - 2, HOLD + 2, n);
      check_bit("long mode again", 1'b0, o_watchdog_normal);
      wait_level(1'b1, n);
      check_span("long timeout", LONG, LONG + 6, n);
      wait_level(1'b0, n);
      @(posedge i_ref_clk) i_watchdog_open <= 1'b1;
      repeat (LONG + 40) @(posedge i_ref_clk);
      @(negedge i_ref_clk) check_bit("open toggle quiet", 1'b0, o_reset_out);
      close_out();
   end
endmodule : supply_reset_supervisor_test
bind supply_reset_supervisor supervisor_chk #(.LONG_WD_CYCLES(LONG_WD_CYCLES),
   .NORMAL_WD_CYCLES(NORMAL_WD_CYCLES), .HOLD_CYCLES(HOLD_CYCLES),
   .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) chk (.i_ref_clk, .i_rst_n, .i_primary_supply_low,
   .i_secondary_supply_low, .i_aux_monitor_low, .i_power_fail_sense_low, .i_manual_reset_n,
   .i_watchdog_toggle_in, .i_watchdog_open, .o_power_fail_flag_n, .o_reset_out,
   .o_reset_out_a_n, .o_reset_out_a_oe, .o_reset_out_b_n, .o_reset_out_b_oe,
   .o_watchdog_normal, .o_watchdog_expired);
`default_nettype wire

// file: include/supervisor_pkg.sv
// Summary of operation
// [R01] power-fail flag low while sense below reference
// [R02] power-fail flag releases at once, no hold; the code releases it only after the synchroniser and state register delay
// [R03] any supply, aux or manual fault resets
// [R04] active-high reset high on any reset cause
// [R05] reset held full timeout after cause clears
// [R06] new fault during hold restarts timeout
// [R07] both open-drain resets share one state
// [R08] manual low resets, then hold time
// [R09] floating manual input counts as inactive
// [R10] switch bounce gives one clean reset
// [R11] stuck watchdog toggle input causes reset
// [R12] watchdog has long initial, short normal mode
// [R13] every reset restarts watchdog in long mode
// [R14] processor toggles watchdog within long period
// [R15] watchdog counter cleared by reset or edge
// [R16] first toggle edge switches to normal mode
// [R17] unconnected toggle input disables the watchdog
// [R18] timeouts counted on clock, fixed at build
// [R19] inputs synchronised, supply faults reset at once
package supervisor_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_KHZ         = 25000;
   localparam int unsigned LONG_WD_MS      = 35000;
   localparam int unsigned NORMAL_WD_MS    = 1120;
   localparam int unsigned RESET_HOLD_MS   = 200;
   localparam int unsigned DEBOUNCE_MS     = 1;
   localparam int unsigned LONG_WD_CYC     = LONG_WD_MS * CLK_KHZ;
   localparam int unsigned NORMAL_WD_CYC   = NORMAL_WD_MS * CLK_KHZ;
   localparam int unsigned RESET_HOLD_CYC  = RESET_HOLD_MS * CLK_KHZ;
   localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * CLK_KHZ;
   localparam int unsigned CNT_W           = 32;

   // ----------------------------------------------------------------
   // synchroniser bit layout
   // ----------------------------------------------------------------
   localparam int unsigned SYNC_W          = 7;
   localparam int unsigned SB_PRIMARY      = 0;
   localparam int unsigned SB_SECONDARY    = 1;
   localparam int unsigned SB_AUX          = 2;
   localparam int unsigned SB_POWER_FAIL   = 3;
   localparam int unsigned SB_MANUAL_N     = 4;
   localparam int unsigned SB_TOGGLE       = 5;
   localparam int unsigned SB_WD_OPEN      = 6;
   // faults taken as present until seen otherwise, manual idle high
   localparam logic [SYNC_W-1:0] SYNC_RST  = 7'h1F;

   // ----------------------------------------------------------------
   // reset sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_FAULT = 3'b001,
      ST_HOLD  = 3'b010,
      ST_RUN   = 3'b100
   } seq_state_t;

endpackage : supervisor_pkg

// file: rtl/input_sync.sv
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
   parameter int unsigned      W       = 1,
   parameter logic [W-1:0]     RST_VAL = '0
) (
   input  wire logic           i_ref_clk,
   input  wire logic           i_rst_n,
   input  wire logic [W-1:0]   i_async,
   output logic      [W-1:0]   o_sync
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } sync_st_t;

   sync_st_t st_reg;
   sync_st_t st_next;

   // a bit moves only once stages two and three agree
   always_comb begin
      st_next    = st_reg;
      st_next.s1 = i_async;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      st_next.q  = (st_reg.s2 & st_reg.s3)
                 | (st_reg.q & (st_reg.s2 ^ st_reg.s3));
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_sync = st_reg.q;

endmodule : input_sync
`default_nettype wire

// file: rtl/supply_reset_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
module supply_reset_supervisor
   import supervisor_pkg::*;
#(
   parameter logic [31:0] LONG_WD_CYCLES   = supervisor_pkg::LONG_WD_CYC,
   parameter logic [31:0] NORMAL_WD_CYCLES = supervisor_pkg::NORMAL_WD_CYC,
   parameter logic [31:0] HOLD_CYCLES      = supervisor_pkg::RESET_HOLD_CYC,
   parameter logic [31:0] DEBOUNCE_CYCLES  = supervisor_pkg::DEBOUNCE_CYC
) (
   input  wire logic i_ref_clk,
   input  wire logic i_rst_n,
   // comparator flags, high while the input is under threshold
   input  wire logic i_primary_supply_low,
   input  wire logic i_secondary_supply_low,
   input  wire logic i_aux_monitor_low,
   input  wire logic i_power_fail_sense_low,
   // pin level after the on-chip pull-up
   input  wire logic i_manual_reset_n,
   input  wire logic i_watchdog_toggle_in,
   // high when the open-pin detector sees nothing driving the toggle
   input  wire logic i_watchdog_open,
   output logic      o_power_fail_flag_n,
   output logic      o_reset_out,
   output logic      o_reset_out_a_n,
   output logic      o_reset_out_a_oe,
   output logic      o_reset_out_b_n,
   output logic      o_reset_out_b_oe,
   output logic      o_watchdog_normal,
   output logic      o_watchdog_expired
);

   import supervisor_pkg::*;

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] sync_in;

   always_comb begin
      raw_in                = '0;
      raw_in[SB_PRIMARY]    = i_primary_supply_low;
      raw_in[SB_SECONDARY]  = i_secondary_supply_low;
      raw_in[SB_AUX]        = i_aux_monitor_low;
      raw_in[SB_POWER_FAIL] = i_power_fail_sense_low;
      raw_in[SB_MANUAL_N]   = i_manual_reset_n;
      raw_in[SB_TOGGLE]     = i_watchdog_toggle_in;
      raw_in[SB_WD_OPEN]    = i_watchdog_open;
   end

   // [R19] inputs synchronised first
   input_sync #(
      .W       (SYNC_W),
      .RST_VAL (SYNC_RST)
   ) u_input_sync (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_async   (raw_in),
      .o_sync    (sync_in)
   );

   logic supply_fault_s;
   logic manual_low_s;
   logic toggle_s;
   logic wd_open_s;
   logic power_fail_s;

   // [R03] supply and aux faults
   assign supply_fault_s = sync_in[SB_PRIMARY]
                         | sync_in[SB_SECONDARY]
                         | sync_in[SB_AUX];
   // [R09] pulled-up input idles inactive
   assign manual_low_s   = ~sync_in[SB_MANUAL_N];
   assign toggle_s       = sync_in[SB_TOGGLE];
   assign wd_open_s      = sync_in[SB_WD_OPEN];
   assign power_fail_s   = sync_in[SB_POWER_FAIL];

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      seq_state_t       seq;
      logic [CNT_W-1:0] hold_cnt;
      logic [CNT_W-1:0] wd_cnt;
      logic [CNT_W-1:0] deb_cnt;
      logic             manual_active;
      logic             wd_normal;
      logic             toggle_prev;
      logic             wd_expired;
      logic             reset_active;
      logic             power_fail;
   } sup_st_t;

   sup_st_t st_reg;
   sup_st_t st_next;

   logic             reset_cause;
   logic             toggle_edge;
   logic [CNT_W-1:0] wd_limit;
   logic             wd_timeout;

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      st_next            = st_reg;
      st_next.wd_expired = 1'b0;
      st_next.power_fail = power_fail_s;
      st_next.toggle_prev = toggle_s;

      // manual reset debounce: low acts at once, release must stand
      // still for the debounce span, so bounce gives one reset
      // [R10] debounce release
      if (manual_low_s) begin
         st_next.manual_active = 1'b1;
         st_next.deb_cnt       = '0;
      end else if (st_reg.manual_active) begin
         if (st_reg.deb_cnt == DEBOUNCE_CYCLES - 32'h1) begin
            st_next.manual_active = 1'b0;
            st_next.deb_cnt       = '0;
         end else begin
            st_next.deb_cnt = st_reg.deb_cnt + 32'h1;
         end
      end

      // [R03] any cause forces reset
      reset_cause = supply_fault_s | st_reg.manual_active;

      // [R12] period depends on mode
      wd_limit   = st_reg.wd_normal ? NORMAL_WD_CYCLES : LONG_WD_CYCLES;
      toggle_edge = toggle_s ^ st_reg.toggle_prev;
      wd_timeout = 1'b0;

      case (st_reg.seq)
         ST_FAULT: begin
            st_next.hold_cnt = '0;
            // [R05] hold starts once causes clear
            // [R08] manual release starts hold
            if (!reset_cause) begin
               st_next.seq = ST_HOLD;
            end
         end
         ST_HOLD: begin
            // [R18] hold counted in clock cycles
            // [R06] new fault restarts timeout
            if (reset_cause) begin
               st_next.seq      = ST_FAULT;
               st_next.hold_cnt = '0;
            end else if (st_reg.hold_cnt == HOLD_CYCLES - 32'h1) begin
               st_next.seq      = ST_RUN;
               st_next.hold_cnt = '0;
            end else begin
               st_next.hold_cnt = st_reg.hold_cnt + 32'h1;
            end
         end
         ST_RUN: begin
            if (reset_cause) begin
               st_next.seq = ST_FAULT;
            end else if (!wd_open_s && !toggle_edge
                         && st_reg.wd_cnt == wd_limit - 32'h1) begin
               // [R11] stuck toggle expires
               wd_timeout       = 1'b1;
               st_next.seq      = ST_HOLD;
               st_next.hold_cnt = '0;
            end
         end
         default: begin
            st_next.seq      = ST_FAULT;
            st_next.hold_cnt = '0;
         end
      endcase

      // watchdog counter only runs while reset is released
      if (st_next.seq != ST_RUN || st_reg.seq != ST_RUN) begin
         // [R15] cleared during reset
         // [R13] reset restarts long mode
         st_next.wd_cnt    = '0;
         st_next.wd_normal = 1'b0;
      end else if (wd_open_s) begin
         // [R17] open input disables watchdog
         st_next.wd_cnt = '0;
      end else if (toggle_edge) begin
         // [R15] edge clears counter
         // [R16] first edge selects normal
         st_next.wd_cnt    = '0;
         st_next.wd_normal = 1'b1;
      end else begin
         st_next.wd_cnt = st_reg.wd_cnt + 32'h1;
      end

      st_next.wd_expired   = wd_timeout;
      // [R04] reset level from sequencer
      st_next.reset_active = (st_next.seq != ST_RUN);
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg.seq           <= ST_FAULT;
         st_reg.hold_cnt      <= '0;
         st_reg.wd_cnt        <= '0;
         st_reg.deb_cnt       <= '0;
         st_reg.manual_active <= 1'b0;
         st_reg.wd_normal     <= 1'b0;
         st_reg.toggle_prev   <= 1'b0;
         st_reg.wd_expired    <= 1'b0;
         st_reg.reset_active  <= 1'b1;
         st_reg.power_fail    <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   logic reset_now;

   // [R19] raw supply faults bypass sync
   // the raw path trades glitch immunity for zero assertion latency
   assign reset_now = st_reg.reset_active
                    | i_primary_supply_low
                    | i_secondary_supply_low
                    | i_aux_monitor_low;

   // [R04] active-high reset
   assign o_reset_out = reset_now;

   // [R07] both outputs share state
   assign o_reset_out_a_n  = 1'b0;
   assign o_reset_out_a_oe = reset_now;
   assign o_reset_out_b_n  = 1'b0;
   assign o_reset_out_b_oe = reset_now;

   // [R01] flag low on comparator
   // [R02] release only after the synchroniser and state register delay, not at once
   assign o_power_fail_flag_n = ~(i_power_fail_sense_low | st_reg.power_fail);

   assign o_watchdog_normal  = st_reg.wd_normal;
   assign o_watchdog_expired = st_reg.wd_expired;

endmodule : supply_reset_supervisor
`default_nettype wire
